//--- rtl/tpm_timer_top.sv
// tpm_timer_top: 16-bit timer core with pwm mode and dual-compare (dual_compare_mode_select) mode.
// assumes: all control bits are static ports from software, all inputs are
// synchronous to clk_sys; pin a of the timer feeds external_trigger_in.
`timescale 1ns/1ns
module tpm_timer_top
  import tpm_pkg::*;
#(
  parameter int unsigned CNT_W = TPM_CNT_W
)
(
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic count_start,
  input wire logic dual_compare_mode_select_n,
  input wire logic pwm_select_b,
  input wire logic pwm_select_c,
  input wire logic pwm_select_d,
  input wire logic buffer_enable_b,
  input wire logic clear_on_match_a,
  input wire logic stop_on_match_a,
  input wire logic [1:0] trigger_edge_sel,
  input wire logic initial_level_b,
  input wire logic initial_level_c,
  input wire logic initial_level_d,
  input wire logic polarity_b,
  input wire logic polarity_c,
  input wire logic polarity_d,
  input wire logic io_ctrl_b_top,
  input wire logic io_ctrl_c_top,
  input wire logic io_ctrl_d_top,
  input wire logic external_trigger_in,
  input wire logic gr_wr_en,
  input wire logic [1:0] gr_wr_sel,
  input wire logic [CNT_W-1:0] gr_wr_data,
  input wire logic match_a_flag_clr,
  output logic match_a_flag,
  output logic [CNT_W-1:0] timer_counter_value,
  output logic [CNT_W-1:0] general_reg_a,
  output logic [CNT_W-1:0] general_reg_b,
  output logic [CNT_W-1:0] general_reg_c,
  output logic [CNT_W-1:0] general_reg_d,
  output logic timer_pin_b_out,
  output logic timer_pin_b_oe,
  output logic timer_pin_c_out,
  output logic timer_pin_c_oe,
  output logic timer_pin_d_out,
  output logic timer_pin_d_oe
);

  localparam logic [CNT_W-1:0] CNT_STEP = CNT_W'(1);

  typedef struct packed {
    tpm_state_t st;
    logic [CNT_W-1:0] cnt;
    logic [CNT_W-1:0] gra;
    logic [CNT_W-1:0] grb;
    logic [CNT_W-1:0] grc;
    logic [CNT_W-1:0] grd;
    logic pin_b2;
    logic flag_a;
  } tpm_core_st_t;

  tpm_core_st_t state_q;
  tpm_core_st_t state_d;

  logic mode_dual_compare_mode_select;
  logic mode_pwm;
  logic running;
  logic match_a;
  logic match_b;
  logic match_c;
  logic match_d;
  logic trig_en;
  logic trig_edge;
  logic trig_ok;
  logic xfer_db;
  logic [TPM_NUM_CH-1:0] ch_sel;
  logic [TPM_NUM_CH-1:0] ch_init;
  logic [TPM_NUM_CH-1:0] ch_pol;
  logic [TPM_NUM_CH-1:0] ch_match;
  logic [TPM_NUM_CH-1:0] ch_equal;
  logic [TPM_NUM_CH-1:0] ch_level;
  logic io_top_unused;

  // the io-control top bits have no effect in the modes built here
  assign io_top_unused = io_ctrl_b_top ^ io_ctrl_c_top ^ io_ctrl_d_top;

  // mode decode; the select bit is active low
  assign mode_dual_compare_mode_select = !dual_compare_mode_select_n;
  assign mode_pwm = dual_compare_mode_select_n;
  assign running = state_q.st == TPM_ST_RUN;

  // compares are only live while counting, so a halted zero never fires them
  assign match_a = running && (state_q.cnt == state_q.gra);
  assign match_b = running && (state_q.cnt == state_q.grb);
  assign match_c = running && (state_q.cnt == state_q.grc);
  assign match_d = running && (state_q.cnt == state_q.grd);

  tpm_edge u_edge (
    .clk_sys(clk_sys),
    .rst(rst),
    .edge_sel(trigger_edge_sel),
    .trig_in(external_trigger_in),
    .trig_edge(trig_edge)
  );

  // edges count only in dual_compare_mode_select, with count-start set, while pin b sits at its initial level
  assign trig_en = mode_dual_compare_mode_select && (trigger_edge_sel != TPM_TRIG_OFF);
  assign trig_ok = trig_en && trig_edge && count_start && (state_q.st != TPM_ST_IDLE)
                   && (state_q.pin_b2 == initial_level_b);

  // buffer d into b: dual_compare_mode_select on period match or accepted edge, pwm on duty match b
  always_comb begin
    if (!buffer_enable_b) begin
      xfer_db = 1'h0;
    end else if (mode_dual_compare_mode_select) begin
      xfer_db = match_a || trig_ok;
    end else begin
      xfer_db = pwm_select_b && match_b;
    end
  end

  // core next-state: sequencing, counter, registers, dual_compare_mode_select pin and flag
  always_comb begin
    state_d = state_q;
    unique case (state_q.st)
      TPM_ST_IDLE: begin
        if (count_start) begin
          state_d.st = (trig_en && stop_on_match_a) ? TPM_ST_WAIT : TPM_ST_RUN;
        end
      end
      TPM_ST_WAIT: begin
        if (!count_start) begin
          state_d.st = TPM_ST_IDLE;
        end else if (trig_ok) begin
          state_d.st = TPM_ST_RUN;
        end
      end
      TPM_ST_RUN: begin
        if (!count_start) begin
          state_d.st = TPM_ST_IDLE;
        end else if (match_a && clear_on_match_a && stop_on_match_a) begin
          state_d.st = TPM_ST_HALT;
        end
      end
      TPM_ST_HALT: begin
        if (!count_start) begin
          state_d.st = TPM_ST_IDLE;
        end else if (trig_ok) begin
          state_d.st = TPM_ST_RUN;
        end
      end
    endcase
    // counter: clear on period match or accepted edge, else step while running
    if (trig_ok) begin
      state_d.cnt = '0;
    end else if (running && count_start) begin
      if (match_a && clear_on_match_a) begin
        state_d.cnt = '0;
      end else begin
        state_d.cnt = state_q.cnt + CNT_STEP;
      end
    end
    // software writes first; a same-cycle hardware transfer into b wins
    if (gr_wr_en) begin
      unique case (gr_wr_sel)
        TPM_GR_SEL_A: state_d.gra = gr_wr_data;
        TPM_GR_SEL_B: state_d.grb = gr_wr_data;
        TPM_GR_SEL_C: state_d.grc = gr_wr_data;
        TPM_GR_SEL_D: state_d.grd = gr_wr_data;
      endcase
    end
    if (xfer_db) begin
      state_d.grb = state_q.grd;
    end
    // dual_compare_mode_select pin: match b drives initial level, match c its inverse; b wins a tie
    if (!mode_dual_compare_mode_select || !count_start || state_q.st == TPM_ST_IDLE) begin
      state_d.pin_b2 = initial_level_b;
    end else if (match_b) begin
      state_d.pin_b2 = initial_level_b;
    end else if (match_c) begin
      state_d.pin_b2 = !initial_level_b;
    end
    // sticky period-match flag; a new match beats a clear in the same cycle
    if (match_a) begin
      state_d.flag_a = 1'h1;
    end else if (match_a_flag_clr) begin
      state_d.flag_a = 1'h0;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      state_q <= '0;
    end else begin
      state_q <= state_d;
    end
  end

  // per-channel control vectors, index 0..2 for pins b..d
  assign ch_sel = {pwm_select_d, pwm_select_c, pwm_select_b};
  assign ch_init = {!(initial_level_d ^ polarity_d), !(initial_level_c ^ polarity_c),
                    !(initial_level_b ^ polarity_b)};
  assign ch_pol = {polarity_d, polarity_c, polarity_b};
  assign ch_match = {match_d, match_c, match_b};
  assign ch_equal = {state_q.gra == state_q.grd, state_q.gra == state_q.grc,
                     state_q.gra == state_q.grb};

  // three independent pwm phases share the period match
  for (genvar i = 0; i < TPM_NUM_CH; i++) begin : g_ch
    tpm_chan_if ch_if ();
    assign ch_if.run = running;
    assign ch_if.active = mode_pwm && ch_sel[i];
    assign ch_if.match_a = match_a;
    assign ch_if.match_x = ch_match[i];
    assign ch_if.equal = ch_equal[i];
    assign ch_if.init_lvl = ch_init[i];
    assign ch_if.pol = ch_pol[i];
    assign ch_level[i] = ch_if.level;
    tpm_chan u_chan (
      .clk_sys(clk_sys),
      .rst(rst),
      .ch(ch_if)
    );
  end

  // pin drive: dual_compare_mode_select owns pin b only, c and d stay released as ports
  assign timer_pin_b_out = mode_dual_compare_mode_select ? state_q.pin_b2 : ch_level[0];
  assign timer_pin_b_oe = mode_dual_compare_mode_select || (pwm_select_b && !io_top_unused) ||
                          (pwm_select_b && io_top_unused);
  assign timer_pin_c_out = ch_level[1];
  assign timer_pin_c_oe = mode_pwm && pwm_select_c;
  assign timer_pin_d_out = ch_level[2];
  assign timer_pin_d_oe = mode_pwm && pwm_select_d;
  assign timer_counter_value = state_q.cnt;
  assign general_reg_a = state_q.gra;
  assign general_reg_b = state_q.grb;
  assign general_reg_c = state_q.grc;
  assign general_reg_d = state_q.grd;
  assign match_a_flag = state_q.flag_a;

  period_clear_a: assert property (@(posedge clk_sys) disable iff (rst)
    (match_a && clear_on_match_a && count_start && !trig_ok)
      |=> (timer_counter_value == '0) && match_a_flag)
    else $error("period match did not clear counter and set flag");

  halt_stop_a: assert property (@(posedge clk_sys) disable iff (rst)
    (match_a && clear_on_match_a && stop_on_match_a && count_start)
      |=> (state_q.st == TPM_ST_HALT) && (timer_counter_value == '0))
    else $error("counter did not halt at zero after period match");

  count_step_a: assert property (@(posedge clk_sys) disable iff (rst)
    (running && count_start && !match_a && !trig_ok)
      |=> (timer_counter_value == CNT_W'($past(timer_counter_value) + CNT_STEP)))
    else $error("running counter did not step by one");

  start_stop_a: assert property (@(posedge clk_sys) disable iff (rst)
    (!count_start && mode_dual_compare_mode_select) |=> (state_q.st == TPM_ST_IDLE)
      && (timer_pin_b_out == $past(initial_level_b)))
    else $error("count-start low did not stop and restore pin b");

  buf_period_a: assert property (@(posedge clk_sys) disable iff (rst)
    (mode_dual_compare_mode_select && buffer_enable_b && match_a) |=> (general_reg_b == $past(general_reg_d)))
    else $error("period match did not reload b from d");

  trig_ignore_a: assert property (@(posedge clk_sys) disable iff (rst)
    (mode_dual_compare_mode_select && trig_edge && (state_q.pin_b2 != initial_level_b) && !match_a
      && !gr_wr_en) |=> $stable(general_reg_b))
    else $error("ignored trigger edge still reloaded b");

  trig_clear_a: assert property (@(posedge clk_sys) disable iff (rst)
    trig_ok |=> (timer_counter_value == '0))
    else $error("accepted trigger edge did not clear counter");

  wait_hold_a: assert property (@(posedge clk_sys) disable iff (rst)
    (state_q.st == TPM_ST_WAIT && count_start && !trig_ok)
      |=> (state_q.st == TPM_ST_WAIT) && $stable(timer_counter_value))
    else $error("one-shot wait did not hold the counter");

  dual_compare_mode_select_level_a: assert property (@(posedge clk_sys) disable iff (rst)
    (mode_dual_compare_mode_select && count_start && match_c && !match_b)
      |=> (timer_pin_b_out == !$past(initial_level_b)))
    else $error("match c did not drive the inverse level");

  dual_compare_mode_select_pins_a: assert property (@(posedge clk_sys) disable iff (rst)
    mode_dual_compare_mode_select |-> timer_pin_b_oe && !timer_pin_c_oe && !timer_pin_d_oe)
    else $error("dual_compare_mode_select drives pins other than b");

  one_shot_c: cover property (@(posedge clk_sys) disable iff (rst)
    (state_q.st == TPM_ST_RUN) ##1 (state_q.st == TPM_ST_HALT));

  trig_start_c: cover property (@(posedge clk_sys) disable iff (rst)
    (state_q.st == TPM_ST_WAIT) ##1 (state_q.st == TPM_ST_RUN));

  pwm_reload_c: cover property (@(posedge clk_sys) disable iff (rst)
    mode_pwm && xfer_db);

endmodule : tpm_timer_top

//--- rtl/tpm_pkg.sv
// tpm_pkg: shared constants for the pwm / dual-compare timer block.
// assumes: every rtl module of the block imports the whole package; tpm_chan_if imports none.
package tpm_pkg;

  // default counter and general-register width
  localparam int unsigned TPM_CNT_W = 16;

  // trigger-edge select field codes
  localparam logic [1:0] TPM_TRIG_OFF = 2'h0;
  localparam logic [1:0] TPM_TRIG_RISE = 2'h1;
  localparam logic [1:0] TPM_TRIG_FALL = 2'h2;
  localparam logic [1:0] TPM_TRIG_BOTH = 2'h3;

  // general-register write select codes
  localparam logic [1:0] TPM_GR_SEL_A = 2'h0;
  localparam logic [1:0] TPM_GR_SEL_B = 2'h1;
  localparam logic [1:0] TPM_GR_SEL_C = 2'h2;
  localparam logic [1:0] TPM_GR_SEL_D = 2'h3;

  // number of pwm-mode output channels (pins b, c, d)
  localparam int unsigned TPM_NUM_CH = 3;

  // counter sequencing states
  typedef enum logic [1:0] {
    TPM_ST_IDLE,
    TPM_ST_WAIT,
    TPM_ST_RUN,
    TPM_ST_HALT
  } tpm_state_t;

  // edge decode of the trigger field; called by the detector only, its checks decode on their own
  function automatic logic tpm_edge_hit(input logic [1:0] sel, input logic prev,
                                        input logic cur);
    logic rise;
    logic fall;
    rise = !prev && cur;
    fall = prev && !cur;
    unique case (sel)
      TPM_TRIG_OFF: tpm_edge_hit = 1'h0;
      TPM_TRIG_RISE: tpm_edge_hit = rise;
      TPM_TRIG_FALL: tpm_edge_hit = fall;
      TPM_TRIG_BOTH: tpm_edge_hit = rise || fall;
    endcase
  endfunction : tpm_edge_hit

endpackage : tpm_pkg

//--- rtl/tpm_chan_if.sv
// tpm_chan_if: control and result wires between the timer core and one pwm channel.
// assumes: the core drives the ctl side, one channel instance the chan side.
`timescale 1ns/1ns
interface tpm_chan_if;
  logic run;
  logic active;
  logic match_a;
  logic match_x;
  logic equal;
  logic init_lvl;
  logic pol;
  logic level;

  modport ctl (output run, output active, output match_a, output match_x,
               output equal, output init_lvl, output pol, input level);
  modport chan (input run, input active, input match_a, input match_x,
                input equal, input init_lvl, input pol, output level);
endinterface : tpm_chan_if

//--- rtl/tpm_edge.sv
// tpm_edge: edge detector for the external trigger input.
// assumes: trigger input is already synchronous to clk_sys.
`timescale 1ns/1ns
module tpm_edge
  import tpm_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic [1:0] edge_sel,
  input wire logic trig_in,
  output logic trig_edge
);

  typedef struct packed {
    logic prev;
  } tpm_edge_st_t;

  tpm_edge_st_t state_q;
  tpm_edge_st_t state_d;

  // remember the last sample; the edge pulse is a pure decode of it against the live input
  always_comb begin
    state_d = state_q;
    state_d.prev = trig_in;
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      state_q <= '0;
    end else begin
      state_q <= state_d;
    end
  end

  assign trig_edge = tpm_edge_hit(edge_sel, state_q.prev, trig_in);

  fall_decode_a: assert property (@(posedge clk_sys) disable iff (rst)
    (edge_sel == TPM_TRIG_FALL) |-> (trig_edge == (state_q.prev && !trig_in)))
    else $error("falling-edge select does not follow the trigger input");

  off_quiet_a: assert property (@(posedge clk_sys) disable iff (rst)
    (edge_sel == TPM_TRIG_OFF) |-> !trig_edge)
    else $error("edge reported while trigger is disabled");

endmodule : tpm_edge

//--- rtl/tpm_chan.sv
// tpm_chan: one pwm-mode output channel (pin b, c or d).
// assumes: match strobes come from the core, valid only while the counter runs.
`timescale 1ns/1ns
module tpm_chan
  import tpm_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst,
  tpm_chan_if.chan ch
);

  typedef struct packed {
    logic level;
  } tpm_chan_st_t;

  tpm_chan_st_t state_q;
  tpm_chan_st_t state_d;

  // idle or unselected pins sit at the initial level; equal registers freeze the pin
  always_comb begin
    state_d = state_q;
    if (!ch.active || !ch.run) begin
      state_d.level = ch.init_lvl;
    end else if (ch.equal) begin
      state_d.level = state_q.level;
    end else if (ch.match_x) begin
      state_d.level = ch.pol;
    end else if (ch.match_a) begin
      state_d.level = !ch.pol;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      state_q <= '0;
    end else begin
      state_q <= state_d;
    end
  end

  assign ch.level = state_q.level;

  duty_level_a: assert property (@(posedge clk_sys) disable iff (rst)
    (ch.active && ch.run && ch.match_x && !ch.equal) |=> (ch.level == $past(ch.pol)))
    else $error("duty match did not drive the active level");

  equal_hold_a: assert property (@(posedge clk_sys) disable iff (rst)
    (ch.active && ch.run && ch.equal) |=> $stable(ch.level))
    else $error("pin changed although period and duty are equal");

  init_level_a: assert property (@(posedge clk_sys) disable iff (rst)
    (!ch.active) |=> (ch.level == $past(ch.init_lvl)))
    else $error("unselected pin not at its initial level");

endmodule : tpm_chan

//--- verif/tpm_trig_src.sv
// tpm_trig_src: far side of the timer: pin loads and the trigger source.
// assumes: fire is a one-cycle request from the bench, synchronous to clk_sys.
`timescale 1ns/1ns
module tpm_trig_src (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic fire,
  input wire logic [2:0] pin_out,
  input wire logic [2:0] pin_oe,
  output logic trig,
  output logic [2:0] pin_lvl
);
  logic [1:0] low_q;
  // loads carry pull-downs, so a released pin reads low, never the last value
  assign pin_lvl = pin_out & pin_oe;
  // trigger idles high; a request gives a three-cycle low pulse on pin a
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      low_q <= 2'h0;
    end else if (fire) begin
      low_q <= 2'h3;
    end else if (low_q != 2'h0) begin
      low_q <= low_q - 2'h1;
    end
  end
  assign trig = (low_q == 2'h0);
endmodule : tpm_trig_src

//--- verif/timer_pwm_and_dual_compare_mode_select_modes_tb.sv
// timer_pwm_and_dual_compare_mode_select_modes_tb: self-checking bench for the pwm / dual_compare_mode_select timer.
// assumes: tpm_pkg, the rtl files and tpm_trig_src are compiled first.
`timescale 1ns/1ns
module timer_pwm_and_dual_compare_mode_select_modes_tb import tpm_pkg::*;;
  typedef struct packed {logic pol; logic lvl; logic [15:0] gb;
                         logic e0; logic e1; logic e2;} tpm_row_t;
  logic clk_sys = 1'h0;
  logic rst, cs, mode_n, bufb, clr, stp, lvl, pol, iot, gwe, fclr, fire, flag, trig;
  logic [1:0] tsel, gsel;
  logic [15:0] gdat, cnt, ga, gb, gc, gd;
  logic [2:0] pout, poe, plvl, psel;
  int fails = 0;
  int n_tests = 0;
  tpm_row_t rows [5];
  tpm_timer_top u_dut (.clk_sys(clk_sys), .rst(rst), .count_start(cs),
    .dual_compare_mode_select_n(mode_n), .pwm_select_b(psel[0]), .pwm_select_c(psel[1]),
    .pwm_select_d(psel[2]), .buffer_enable_b(bufb), .clear_on_match_a(clr),
    .stop_on_match_a(stp), .trigger_edge_sel(tsel), .initial_level_b(lvl),
    .initial_level_c(lvl), .initial_level_d(lvl), .polarity_b(pol), .polarity_c(pol),
    .polarity_d(pol), .io_ctrl_b_top(iot), .io_ctrl_c_top(iot), .io_ctrl_d_top(iot),
    .external_trigger_in(trig), .gr_wr_en(gwe), .gr_wr_sel(gsel), .gr_wr_data(gdat),
    .match_a_flag_clr(fclr), .match_a_flag(flag), .timer_counter_value(cnt),
    .general_reg_a(ga), .general_reg_b(gb), .general_reg_c(gc), .general_reg_d(gd),
    .timer_pin_b_out(pout[0]), .timer_pin_b_oe(poe[0]), .timer_pin_c_out(pout[1]),
    .timer_pin_c_oe(poe[1]), .timer_pin_d_out(pout[2]), .timer_pin_d_oe(poe[2]));
  tpm_trig_src u_load (.clk_sys(clk_sys), .rst(rst), .fire(fire), .pin_out(pout),
    .pin_oe(poe), .trig(trig), .pin_lvl(plvl));
  // free-running 100 MHz clock
  always #5 clk_sys = ~clk_sys;
  task automatic results();
    $display("checks %0d, mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : results
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      fails++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : chk
  // inputs always move 1 ns after the rising edge, away from sampling
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask : tick
  // strobe drops and one edge passes, so back-to-back calls never re-raise it at once
  task automatic wr(input logic [1:0] sel, input logic [15:0] data);
    gwe = 1'h1;
    gsel = sel;
    gdat = data;
    tick(1);
    gwe = 1'h0;
    tick(1);
  endtask : wr
  task automatic wr4(input logic [63:0] v);
    for (int i = 0; i < 4; i++) begin
      wr(2'(i), v[63-16*i -: 16]);
    end
  endtask : wr4
  // a fresh reset per case, since a stopped counter keeps its value
  task automatic cfg(input logic mn, input logic p, input logic l, input logic bf,
                     input logic c, input logic s, input logic [1:0] ts);
    rst = 1'h1;
    cs = 1'h0;
    mode_n = mn;
    pol = p;
    lvl = l;
    bufb = bf;
    clr = c;
    stp = s;
    tsel = ts;
    tick(2);
    rst = 1'h0;
  endtask : cfg
  task automatic wait_cnt(input logic [15:0] v);
    for (int i = 0; i < 200 && cnt !== v; i++) begin
      tick(1);
    end
    if (cnt !== v) begin
      chk(cnt, v);
      results();
    end
  endtask : wait_cnt
  task automatic pulse_fire();
    fire = 1'h1;
    tick(1);
    fire = 1'h0;
  endtask : pulse_fire
  initial begin
    {rst, cs, mode_n, bufb, clr, stp, lvl, pol, gwe, fclr, fire} = 11'h400;
    {iot, tsel, gsel, gdat} = {1'h1, 2'h0, 2'h0, 16'h0000};
    psel = 3'h7;
    // period 9: duty 3 on all pins, or duty equal to period
    rows = '{'{1'h0, 1'h0, 16'h0003, 1'h1, 1'h0, 1'h1}, '{1'h1, 1'h0, 16'h0003, 1'h0, 1'h1, 1'h0},
             '{1'h0, 1'h1, 16'h0003, 1'h0, 1'h0, 1'h1}, '{1'h1, 1'h1, 16'h0003, 1'h1, 1'h1, 1'h0},
             '{1'h1, 1'h0, 16'h0009, 1'h0, 1'h0, 1'h0}};
    rst = 1'h1;
    tick(16);
    rst = 1'h0;
    tick(1);
    chk(cnt | ga | gb | gc | gd, 16'h0000);
    chk(16'(flag), 16'h0000);
    for (int k = 0; k < 5; k++) begin
      cfg(1'h1, rows[k].pol, rows[k].lvl, 1'h0, 1'h1, 1'h0, TPM_TRIG_OFF);
      wr4({16'h0009, rows[k].gb, rows[k].gb, rows[k].gb});
      cs = 1'h1;
      wait_cnt(16'h0002);
      chk(16'(plvl), 16'({3{rows[k].e0}}));
      wait_cnt(16'h0006);
      chk(16'(plvl), 16'({3{rows[k].e1}}));
      wait_cnt(16'h0001);
      chk(16'(plvl), 16'({3{rows[k].e2}}));
      chk(16'(flag), 16'h0001);
    end
    // pwm buffering: match b pulls d into b
    cfg(1'h1, 1'h1, 1'h0, 1'h1, 1'h1, 1'h0, TPM_TRIG_OFF);
    wr4({16'h0009, 16'h0003, 16'h0003, 16'h0005});
    // pin c deselected and io-control top bits flipped; neither may disturb b or d
    psel = 3'h5;
    iot = 1'h0;
    cs = 1'h1;
    wait_cnt(16'h0005);
    chk(gb, 16'h0005);
    chk(16'(plvl), 16'h0001);
    chk(16'(poe), 16'h0005);
    // dual_compare_mode_select one-shot with the trigger off
    cfg(1'h0, 1'h0, 1'h0, 1'h1, 1'h1, 1'h1, TPM_TRIG_OFF);
    wr4({16'h0004, 16'h0003, 16'h0001, 16'h0007});
    chk(16'(poe), 16'h0001);
    cs = 1'h1;
    wait_cnt(16'h0002);
    chk(16'(plvl), 16'h0001);
    wait_cnt(16'h0004);
    chk(16'(plvl), 16'h0000);
    tick(8);
    chk(cnt, 16'h0000);
    chk(16'(plvl), 16'h0000);
    chk(gb, 16'h0007);
    fclr = 1'h1;
    tick(1);
    fclr = 1'h0;
    tick(1);
    chk(16'(flag), 16'h0000);
    // dual_compare_mode_select forced stop in mid pulse
    cfg(1'h0, 1'h0, 1'h0, 1'h0, 1'h1, 1'h0, TPM_TRIG_OFF);
    wr4({16'h0014, 16'h000F, 16'h0002, 16'h0000});
    cs = 1'h1;
    wait_cnt(16'h0006);
    chk(16'(plvl), 16'h0001);
    cs = 1'h0;
    tick(2);
    chk(16'(plvl), 16'h0000);
    tick(3);
    chk(cnt, 16'h0006);
    // trigger-started one-shot: the counter waits for a falling edge
    cfg(1'h0, 1'h0, 1'h0, 1'h1, 1'h1, 1'h1, TPM_TRIG_FALL);
    wr4({16'h001E, 16'h000C, 16'h0004, 16'h0009});
    cs = 1'h1;
    tick(5);
    chk(cnt, 16'h0000);
    pulse_fire();
    wait_cnt(16'h0003);
    chk(gb, 16'h0009);
    wr(TPM_GR_SEL_D, 16'h0014);
    wait_cnt(16'h0006);
    pulse_fire();
    wait_cnt(16'h000A);
    chk(gb, 16'h0009);
    pulse_fire();
    tick(4);
    chk(gb, 16'h0014);
    chk(16'(cnt < 16'h0008), 16'h0001);
    // rising-edge select: the falling half of the pulse must not start the count
    cfg(1'h0, 1'h0, 1'h0, 1'h1, 1'h1, 1'h1, TPM_TRIG_RISE);
    wr4({16'h001E, 16'h000C, 16'h0004, 16'h0009});
    cs = 1'h1;
    tick(2);
    pulse_fire();
    tick(3);
    chk(cnt, 16'h0000);
    chk(gb, 16'h000C);
    tick(3);
    chk(cnt, 16'h0002);
    chk(gb, 16'h0009);
    // delayed pulse: clear-on-match enabled last, counting goes on past match a
    cfg(1'h0, 1'h0, 1'h0, 1'h1, 1'h0, 1'h0, TPM_TRIG_FALL);
    clr = 1'h1;
    wr4({16'h001E, 16'h000C, 16'h0004, 16'h0009});
    cs = 1'h1;
    wait_cnt(16'h0002);
    pulse_fire();
    wait_cnt(16'h0005);
    chk(16'(plvl), 16'h0001);
    chk(gb, 16'h0009);
    wait_cnt(16'h000A);
    chk(16'(plvl), 16'h0000);
    // reset in mid-count must bring counter, registers and flag back to zero
    rst = 1'h1;
    tick(1);
    rst = 1'h0;
    chk(cnt | ga | gb | gc | gd, 16'h0000);
    chk(16'(flag), 16'h0000);
    results();
  end
endmodule : timer_pwm_and_dual_compare_mode_select_modes_tb
